/* File: hdl/regsel_defines.svh */
`ifndef REGSEL_DEFINES_SVH
`define REGSEL_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_KEEP_ON      12'h000
`define OFS_SET_OFF      12'h004
`define OFS_VSEL         12'h008
`define OFS_SELREG       12'h00c
`define OFS_EN_SET1      12'h010
`define OFS_EN_SET2      12'h014
`define OFS_EN_SET3      12'h018
`define OFS_EN_SET4      12'h01c
`define OFS_DEVCTRL      12'h020
`define OFS_SELMAP       12'h024
`define OFS_STATUS       12'h028
`define OFS_MODE         12'h02c
`define OFS_BANK_DATA    12'h030

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DEVCTRL_SLP_EN   0
`define DEVCTRL_SLP_POL  1
`define DEVCTRL_IRQ_PEND 2
`define DEVCTRL_STATE_LO 4

// ----------------------------------------------------------------
// Reset values and default bank words
// ----------------------------------------------------------------
`define RST_BYTE         8'h00
`define RST_DEVCTRL      8'h00
`define BANK_A_WORD      32'h0000_0000
`define BANK_B_WORD      32'h0000_00ff

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define NUM_RES          8
`define NUM_PINS         4
`define BANK_DEPTH       4

`endif

/* File: hdl/regsel_pkg.sv */
package regsel_pkg;

  // Device operating states seen by this block
  typedef enum logic [2:0] {
    DEV_OFF,
    DEV_CONFIG,
    DEV_ACTIVE,
    DEV_SLEEP
  } dev_state_t;

  // Per-resource drive mode
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_ON,
    MODE_ECO
  } res_mode_t;

  // Loader sequence
  typedef enum logic [1:0] {
    LD_WAIT,
    LD_COPY,
    LD_DONE
  } load_state_t;

  // Synchronised pin bundle
  typedef struct packed {
    logic [3:0] en;
    logic       sleep;
    logic       power_request_pin;
    logic       first_clock_request_pin;
    logic       second_clock_request_pin;
  } pins_t;

  // Per-resource control bytes
  typedef struct packed {
    logic [7:0] keep_on;
    logic [7:0] set_off;
    logic [7:0] vsel;
    logic [7:0] selreg;
  } res_cfg_t;

endpackage

/* File: hdl/bank_rom.sv */
`timescale 1ns/1ps
`include "regsel_defines.svh"

// Two default banks; read word comes out of a register
module bank_rom (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // Read port
  input  wire logic        bank_i,
  input  wire logic [1:0]  addr_i,
  output logic      [31:0] data_o
);

  // ----------------------------------------------------------------
  // Read register
  // ----------------------------------------------------------------
  // Bank B fills the low byte with ones in word 0 only
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= 32'h0000_0000;
    end else if (bank_i && addr_i == 2'h0) begin
      data_o <= `BANK_B_WORD;
    end else begin
      data_o <= `BANK_A_WORD;
    end
  end

endmodule

/* File: hdl/regsel_top.sv */
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "regsel_defines.svh"

// Functional notes
// - Sleep, keep bit set: stay on
// - Sleep voltage bit picks primary or alternate
// - Sleep, keep and off clear: economy
// - Sleep, off set, keep clear: off
// - Pin-assigned resource ignores device sleep
// - Assigned pin high: active behaviour
// - Assigned pin low: sleep bits apply
// - Pin low, keep set: stays on
// - Pin low, off set, keep clear: disabled
// - Pin low, both clear: economy
// - Pin low, voltage bit selects register
// - Strap low: enable pins select voltage
// - Strap low: request pins use sets 1-3
// - Bank strap sampled during configuration
// - Chosen bank copied into user registers
// - Strap chooses default or alternate roles
// - Sleep pin gated by allow, irq, polarity
// - Host strap zero selects SPI
// - Multiple assigned pins are ORed
// - Enable pins only in active/sleep
module regsel_top (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // AXI4-Lite write
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Device pins
  input  wire logic [3:0]  resource_enable_pin_i,
  input  wire logic        sleep_pin_i,
  input  wire logic        scaling_bus_clock_pin_i,
  input  wire logic        scaling_bus_data_pin_i,
  input  wire logic        pin_function_strap_i,
  input  wire logic        default_bank_strap_i,
  input  wire logic        host_port_strap_i,
  // Sequencer side
  input  wire logic        config_state_i,
  input  wire logic        active_state_i,
  // Resource controls
  output logic [7:0]       res_on_o,
  output logic [7:0]       res_eco_o,
  output logic [7:0]       res_alt_volt_o,
  output logic             dev_sleep_o,
  output logic             host_spi_sel_o,
  output logic             scaling_bus_en_o,
  output logic             load_done_o
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                  s1;
    logic [7:0]                  s2;
    logic [7:0]                  s3;
    regsel_pkg::res_cfg_t        cfg;
    logic [3:0][7:0]             en_set;
    logic [7:0]                  devctrl;
    logic [7:0]                  selmap;
    regsel_pkg::load_state_t     ld;
    logic [1:0]                  ld_cnt;
    logic                        bank;
    logic                        slp;
    logic                        awr;
    logic                        wr;
    logic                        awrdy;
    logic                        wrdy;
    logic                        arrdy;
    logic [11:0]                 awa;
    logic [31:0]                 wd;
    logic [3:0]                  ws;
    logic                        bv;
    logic                        rv;
    logic [31:0]                 rd;
    logic [1:0]                  rr;
    logic [1:0]                  br;
    logic [7:0]                  on;
    logic [7:0]                  eco;
    logic [7:0]                  alt;
    logic                        spi;
    logic                        sbe;
    logic                        done;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [31:0] rom_data;
  logic [7:0]  pin_en;
  logic [7:0]  pin_assigned;
  logic [7:0]  pin_sel;
  logic [7:0]  pin_lvl;
  logic [7:0]  rd_data;

  // Synchronised pins: bit order en[3:0], sleep, sclk, sdat, strap
  regsel_pkg::pins_t sy;
  assign sy.en       = st_r.s2[3:0];
  assign sy.sleep    = st_r.s2[4];
  assign sy.first_clock_request_pin = st_r.s2[5];
  assign sy.second_clock_request_pin = st_r.s2[6];
  assign sy.power_request_pin  = st_r.s2[4];

  // ----------------------------------------------------------------
  // Default bank store
  // ----------------------------------------------------------------
  bank_rom u_rom (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .bank_i    (st_r.bank),
    .addr_i    (st_r.ld_cnt),
    .data_o    (rom_data)
  );

  // ----------------------------------------------------------------
  // Per-resource pin decode
  // ----------------------------------------------------------------
  // Strap low remaps the request pins onto sets 1..3; set 4 unused
  genvar g;
  generate
    for (g = 0; g < `NUM_RES; g++) begin : g_res
      logic [3:0] src;
      logic [3:0] asg;
      always_comb begin
        asg = {st_r.en_set[3][g], st_r.en_set[2][g],
               st_r.en_set[1][g], st_r.en_set[0][g]};
        if (st_r.s3[7]) begin
          src = sy.en;
        end else begin
          // Fourth set has no pin here, so it is masked
          src = {1'b0, sy.second_clock_request_pin, sy.first_clock_request_pin, sy.power_request_pin};
          asg[3] = 1'b0;
        end
      end
      assign pin_assigned[g] = |asg;
      assign pin_lvl[g]      = |(asg & src);
      // Select pin for each resource: its former enable, en[g % 4]
      assign pin_sel[g] = sy.en[g % 4];
    end
  endgenerate

  assign pin_en = pin_lvl;

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 8'h00;
    unique case (s_axi_araddr)
      `OFS_KEEP_ON: rd_data = st_r.cfg.keep_on;
      `OFS_SET_OFF: rd_data = st_r.cfg.set_off;
      `OFS_VSEL:    rd_data = st_r.cfg.vsel;
      `OFS_SELREG:  rd_data = st_r.cfg.selreg;
      `OFS_EN_SET1: rd_data = st_r.en_set[0];
      `OFS_EN_SET2: rd_data = st_r.en_set[1];
      `OFS_EN_SET3: rd_data = st_r.en_set[2];
      `OFS_EN_SET4: rd_data = st_r.en_set[3];
      `OFS_DEVCTRL: rd_data = {st_r.slp, st_r.devctrl[6:0]};
      `OFS_SELMAP:  rd_data = st_r.selmap;
      `OFS_STATUS:  rd_data = {st_r.s3[7], st_r.bank, st_r.spi,
                               st_r.done, sy.en};
      `OFS_MODE:    rd_data = st_r.on;
      default:      rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        rd_hit;
    logic        mode_ok;
    logic        act;
    logic        sleep_lvl;
    st_nxt    = st_r;
    rd_hit    = 1'b0;
    mode_ok   = 1'b0;
    act       = 1'b0;
    sleep_lvl = 1'b0;

    // Two flops on enable, sleep, bus and function-strap pins (bank and host straps taken raw); strap level also kept
    st_nxt.s1 = {pin_function_strap_i, scaling_bus_data_pin_i,
                 scaling_bus_clock_pin_i, sleep_pin_i,
                 resource_enable_pin_i};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = {st_r.s2[7], 7'h00};

    // Loader: bank chosen in config, then copied
    unique case (st_r.ld)
      regsel_pkg::LD_WAIT: begin
        if (config_state_i) begin
          st_nxt.bank   = default_bank_strap_i;
          st_nxt.ld     = regsel_pkg::LD_COPY;
          st_nxt.ld_cnt = 2'h0;
        end
      end
      regsel_pkg::LD_COPY: begin
        st_nxt.ld_cnt = st_r.ld_cnt + 2'h1;
        if (st_r.ld_cnt == 2'h1) begin
          st_nxt.cfg.keep_on = rom_data[7:0];
          st_nxt.cfg.set_off = rom_data[15:8];
          st_nxt.cfg.vsel    = rom_data[23:16];
          st_nxt.cfg.selreg  = rom_data[31:24];
        end
        if (st_r.ld_cnt == 2'h3) begin
          st_nxt.ld   = regsel_pkg::LD_DONE;
          st_nxt.done = 1'b1;
        end
      end
      regsel_pkg::LD_DONE: begin
        st_nxt.done = 1'b1;
      end
    endcase

    // Host port follows its strap from reset on, not only after load
    st_nxt.spi = ~host_port_strap_i;

    // Sleep pin: allowed, no irq, polarity, strap high
    sleep_lvl = st_r.s2[4] ^ ~st_r.devctrl[`DEVCTRL_SLP_POL];
    if (st_r.devctrl[`DEVCTRL_SLP_EN] && !st_r.devctrl[`DEVCTRL_IRQ_PEND]
        && st_r.s3[7] && active_state_i) begin
      st_nxt.slp = sleep_lvl;
    end else begin
      st_nxt.slp = 1'b0;
    end
    act     = active_state_i;
    mode_ok = act;

    // Per-resource decision
    for (int i = 0; i < `NUM_RES; i++) begin
      logic lo;
      lo = 1'b0;
      if (!mode_ok) begin
        st_nxt.on[i]  = 1'b0;
        st_nxt.eco[i] = 1'b0;
        st_nxt.alt[i] = st_r.cfg.selreg[i];
      end else begin
        if (pin_assigned[i]) begin
          lo = ~pin_en[i];
        end else begin
          lo = st_r.slp;
        end
        if (!lo) begin
          st_nxt.on[i]  = 1'b1;
          st_nxt.eco[i] = 1'b0;
        end else if (st_r.cfg.keep_on[i]) begin
          st_nxt.on[i]  = 1'b1;
          st_nxt.eco[i] = 1'b0;
        end else if (st_r.cfg.set_off[i]) begin
          st_nxt.on[i]  = 1'b0;
          st_nxt.eco[i] = 1'b0;
        end else begin
          st_nxt.on[i]  = 1'b1;
          st_nxt.eco[i] = 1'b1;
        end
        if (!st_r.s3[7] && st_r.selmap[i]) begin
          st_nxt.alt[i] = pin_sel[i];
        end else if (lo) begin
          st_nxt.alt[i] = st_r.cfg.selreg[i] | st_r.cfg.vsel[i];
        end else begin
          st_nxt.alt[i] = st_r.cfg.selreg[i];
        end
      end
    end
    st_nxt.sbe = st_r.s3[7];

    // AXI write: address and data in either order
    if (s_axi_awvalid && st_r.awrdy) begin
      st_nxt.awr = 1'b1;
      st_nxt.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wrdy) begin
      st_nxt.wr = 1'b1;
      st_nxt.wd = s_axi_wdata;
      st_nxt.ws = s_axi_wstrb;
    end
    if (st_r.awr && st_r.wr) begin
      st_nxt.awr = 1'b0;
      st_nxt.wr  = 1'b0;
      st_nxt.bv  = 1'b1;
      st_nxt.br  = 2'b00;
      if (st_r.ws[0]) begin
        unique case (st_r.awa)
          `OFS_KEEP_ON: st_nxt.cfg.keep_on = st_r.wd[7:0];
          `OFS_SET_OFF: st_nxt.cfg.set_off = st_r.wd[7:0];
          `OFS_VSEL:    st_nxt.cfg.vsel    = st_r.wd[7:0];
          `OFS_SELREG:  st_nxt.cfg.selreg  = st_r.wd[7:0];
          `OFS_EN_SET1: st_nxt.en_set[0]   = st_r.wd[7:0];
          `OFS_EN_SET2: st_nxt.en_set[1]   = st_r.wd[7:0];
          `OFS_EN_SET3: st_nxt.en_set[2]   = st_r.wd[7:0];
          `OFS_EN_SET4: st_nxt.en_set[3]   = st_r.wd[7:0];
          `OFS_DEVCTRL: st_nxt.devctrl     = st_r.wd[7:0];
          `OFS_SELMAP:  st_nxt.selmap      = st_r.wd[7:0];
          `OFS_STATUS, `OFS_MODE: st_nxt.br = 2'b00;
          default:      st_nxt.br = 2'b10;
        endcase
      end
    end
    if (st_r.bv && s_axi_bready) begin
      st_nxt.bv = 1'b0;
    end

    // AXI read: one-cycle accept, data registered
    rd_hit = (s_axi_araddr <= `OFS_MODE) && (s_axi_araddr[1:0] == 2'b00);
    if (s_axi_arvalid && st_r.arrdy) begin
      st_nxt.rv = 1'b1;
      st_nxt.rd = {24'h000000, rd_data};
      st_nxt.rr = rd_hit ? 2'b00 : 2'b10;
    end else if (st_r.rv && s_axi_rready) begin
      st_nxt.rv = 1'b0;
    end

    // Readies from flops; low for one cycle after reset
    st_nxt.awrdy = ~st_nxt.awr & ~st_nxt.bv;
    st_nxt.wrdy  = ~st_nxt.wr & ~st_nxt.bv;
    st_nxt.arrdy = ~st_nxt.rv;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready    = st_r.awrdy;
  assign s_axi_wready     = st_r.wrdy;
  assign s_axi_bvalid     = st_r.bv;
  assign s_axi_bresp      = st_r.br;
  assign s_axi_arready    = st_r.arrdy;
  assign s_axi_rvalid     = st_r.rv;
  assign s_axi_rdata      = st_r.rd;
  assign s_axi_rresp      = st_r.rr;
  assign res_on_o         = st_r.on;
  assign res_eco_o        = st_r.eco;
  assign res_alt_volt_o   = st_r.alt;
  assign dev_sleep_o      = st_r.slp;
  assign host_spi_sel_o   = st_r.spi;
  assign scaling_bus_en_o = st_r.sbe;
  assign load_done_o      = st_r.done;

endmodule

/* File: dv/regsel_checker.sv */
`timescale 1ns/1ps
// ------------------------------------
// Port checks for the mode selector
// ------------------------------------
module regsel_checker (
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  // Straps and sequencer
  input wire logic        host_port_strap_i,
  input wire logic        pin_function_strap_i,
  input wire logic        config_state_i,
  input wire logic        active_state_i,
  // Block outputs
  input wire logic        host_spi_sel_o,
  input wire logic        scaling_bus_en_o,
  input wire logic        dev_sleep_o,
  input wire logic        load_done_o,
  input wire logic [7:0]  res_on_o,
  input wire logic [7:0]  res_eco_o,
  // Read channel
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  logic cfg_seen_r;

  // Config pass seen since reset; a load cannot come first
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      cfg_seen_r <= 1'h0;
    else if (config_state_i)
      cfg_seen_r <= 1'h1;
  end

  a_host_port_sel: assert property (
    $stable(host_port_strap_i)[*5] |-> host_spi_sel_o == !host_port_strap_i)
    else $error("host port select wrong");
  a_scale_bus_en: assert property (
    $stable(pin_function_strap_i)[*5] |->
      scaling_bus_en_o == pin_function_strap_i)
    else $error("scaling bus enable wrong");
  a_strap_no_sleep: assert property (
    !pin_function_strap_i[*5] |-> !dev_sleep_o)
    else $error("sleep with strap low");
  a_idle_all_off: assert property (
    !active_state_i[*3] |-> res_on_o == 8'h00 && res_eco_o == 8'h00)
    else $error("resource on while idle");
  a_load_stays: assert property (load_done_o |=> load_done_o)
    else $error("load done dropped");
  a_load_after_cfg: assert property (load_done_o |-> cfg_seen_r)
    else $error("load before config");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
endmodule

/* File: dv/host_pins_model.sv */
`timescale 1ns/1ps
// ------------------------------------
// Host processor pin driver
// ------------------------------------
module host_pins_model (
  // Clock
  input  wire logic       clk_sys_i,
  // Wanted levels and pace
  input  wire logic [6:0] level_i,
  input  wire logic       slow_i,
  // {sleep, data, clock, enable[3:0]}
  output logic      [6:0] pins_o
);
  logic [6:0] hold_r = 7'h00;

  // Pins move 3 ns off the edge; a slow host lags a cycle
  always @(posedge clk_sys_i) begin
    hold_r <= level_i;
    pins_o <= #3 (slow_i ? hold_r : level_i);
  end
endmodule

/* File: dv/regulator_state_and_voltage_select_tb.sv */
`timescale 1ns/1ps
// ------------------------------------
// Bench for the mode selector
// ------------------------------------
module regulator_state_and_voltage_select_tb;
  logic        clk_sys_i, rst_i, slow;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        pin_function_strap_i, default_bank_strap_i;
  logic        host_port_strap_i, config_state_i, active_state_i;
  logic [7:0]  res_on_o, res_eco_o, res_alt_volt_o;
  logic        dev_sleep_o, host_spi_sel_o, scaling_bus_en_o, load_done_o;
  logic [6:0]  level, pins;
  logic [7:0]  regs_s [10];
  int          n_errors, total_checks;

  // 125 MHz clock
  initial begin
    clk_sys_i = 1'h0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  regsel_top dut_u (
    .clk_sys_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .resource_enable_pin_i(pins[3:0]), .scaling_bus_clock_pin_i(pins[4]),
    .scaling_bus_data_pin_i(pins[5]), .sleep_pin_i(pins[6]),
    .pin_function_strap_i, .default_bank_strap_i, .host_port_strap_i,
    .config_state_i, .active_state_i, .res_on_o, .res_eco_o, .res_alt_volt_o,
    .dev_sleep_o, .host_spi_sel_o, .scaling_bus_en_o, .load_done_o
  );

  host_pins_model host_u (
    .clk_sys_i, .level_i(level), .slow_i(slow), .pins_o(pins)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One transfer; answer ready goes up with the request
  // and stays up until the answer is sampled
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    s_axi_bready <= wr;
    s_axi_rready <= !wr;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys_i);
      if (wr ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready)
        break;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    q = s_axi_rdata;
    rsp = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    if (n == 100) begin
      n_errors++;
      results();
    end
  endtask

  task automatic wreg(input logic [3:0] i, input logic [7:0] v);
    regs_s[i] = v;
    bus(1'h1, {6'h00, i, 2'h0}, {24'h000000, v});
    check(32'(rsp), 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    bus(1'h0, a, 32'h0);
    check(32'(rsp), 32'(er));
    if (er == 2'h0)
      check(q, e);
  endtask

  // Let synchronisers settle, then compare every resource
  task automatic expect_res();
    logic [7:0] on, eco, alt, m;
    logic [3:0] src, asg;
    logic       slp, hi;
    // Slow host, two sync flops, sleep flop, decision flop
    repeat (8) @(posedge clk_sys_i);
    slp = pin_function_strap_i && regs_s[8][0] && !regs_s[8][2] &&
          level[6] == regs_s[8][1] && active_state_i;
    src = pin_function_strap_i ? level[3:0] :
          {1'h0, level[5], level[4], level[6]};
    for (int i = 0; i < 8; i++) begin
      asg = {regs_s[7][i], regs_s[6][i], regs_s[5][i], regs_s[4][i]};
      hi = (asg != 4'h0) ? |(asg & src) : !slp;
      on[i] = active_state_i &&
              (hi || regs_s[0][i] || !regs_s[1][i]);
      eco[i] = active_state_i && !hi && !regs_s[0][i] && !regs_s[1][i];
      alt[i] = regs_s[3][i] || (!hi && regs_s[2][i]);
      if (!pin_function_strap_i && regs_s[9][i])
        alt[i] = level[i % 4];
    end
    m = on | eco;
    check(32'(dev_sleep_o), 32'(slp));
    check(32'(res_eco_o), 32'(eco));
    check(32'(res_on_o), 32'(on));
    check(32'(res_alt_volt_o & m), 32'(alt & m));
  endtask

  initial begin
    int n;
    rst_i = 1'h1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, slow, level} = '0;
    s_axi_wstrb = 4'hf;
    {config_state_i, active_state_i, host_port_strap_i} = 3'h0;
    {pin_function_strap_i, default_bank_strap_i} = 2'h3;
    regs_s = '{default: 8'h00};
    n_errors = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    // Config pass with the bank strap high
    config_state_i <= 1'h1;
    for (n = 0; n < 100 && load_done_o !== 1'h1; n++)
      @(posedge clk_sys_i);
    if (n == 100) begin
      n_errors++;
      results();
    end
    config_state_i <= 1'h0;
    active_state_i <= 1'h1;
    regs_s[0] = 8'hff;
    rd(12'h000, 32'h0000_00ff, 2'h0);
    rd(12'h028, 32'h0000_00f0, 2'h0);
    rd(12'h040, 32'h0, 2'h2);
    $display("bank load test done");
    // Device sleep, every gate combination, unassigned resources
    wreg(0, 8'h03);
    wreg(1, 8'h0d);
    wreg(2, 8'h52);
    for (n = 0; n < 16; n++) begin
      wreg(8, {5'h00, 3'(n)});
      level[6] <= n[3];
      slow <= n[0];
      expect_res();
    end
    $display("device sleep test done");
    // Pin-assigned resources with device sleep toggled below them
    wreg(8, 8'h03);
    wreg(3, 8'h11);
    wreg(4, 8'h0f);
    wreg(5, 8'h30);
    wreg(6, 8'h20);
    wreg(7, 8'h80);
    for (n = 0; n < 32; n++) begin
      level <= {n[4], 2'h0, 4'(n)};
      expect_res();
    end
    $display("enable pin test done");
    // Strap low: request pins enable, enable pins select voltage
    wreg(7, 8'h00);
    wreg(9, 8'hff);
    pin_function_strap_i <= 1'h0;
    host_port_strap_i <= 1'h1;
    for (n = 0; n < 128; n++) begin
      level <= 7'(n);
      expect_res();
    end
    check(32'(host_spi_sel_o), 32'h0);
    check(32'(scaling_bus_en_o), 32'h0);
    $display("strap low test done");
    active_state_i <= 1'h0;
    expect_res();
    $display("idle state test done");
    results();
  end
endmodule

bind regsel_top regsel_checker chk_u (
  .clk_sys_i, .rst_i, .host_port_strap_i, .pin_function_strap_i,
  .config_state_i, .active_state_i, .host_spi_sel_o, .scaling_bus_en_o,
  .dev_sleep_o, .load_done_o, .res_on_o, .res_eco_o, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);
